// File: logic/dbg_gate_pkg.sv
/*
 * shared constants and carrier types for the debug access gate:
 * security code layout, flash read carrier, link frame sizing.
 * assumes a byte-wide flash read port and a serial debug link.
 */
`default_nettype none

package dbg_gate_pkg;

    localparam int ID_BYTES = 10;
    localparam int ID_BITS = ID_BYTES * 8;
    localparam int FLASH_AW = 24;
    localparam logic [FLASH_AW-1:0] ID_ADDR_LO = 24'h00_0070;
    localparam logic [FLASH_AW-1:0] ID_ADDR_HI = 24'h00_0079;
    localparam int EMU_EN_BYTE = ID_BYTES - 1;
    localparam int EMU_EN_BIT = 7;
    localparam int FRAME_CNT_W = 7;
    localparam logic [FRAME_CNT_W-1:0] FRAME_BITS = 7'h50;
    localparam logic [FRAME_CNT_W-1:0] CNT_RST = 7'h00;
    localparam logic [3:0] IDX_RST = 4'h0;
    localparam logic [3:0] IDX_LAST = 4'h9;
    localparam logic SEC_RST = 1'b0;
    localparam logic SWBRK_RST = 1'b1;

    typedef logic [ID_BYTES-1:0][7:0] id_code_t;

    typedef struct packed {
        logic req;
        logic [FLASH_AW-1:0] addr;
    } flash_rd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } flash_rsp_t;

    typedef struct packed {
        logic debug_valid;
        logic emulator_enabled;
        logic security_released;
        logic flash_read_enable;
        logic id_loaded;
    } gate_status_t;

    typedef struct packed {
        logic cpu_reset;
        logic periph_reset;
        logic port_buffer_reset;
    } reset_out_t;

endpackage

`default_nettype wire

// File: logic/sync_stage2.sv
/*
 * two flip-flop synchroniser for levels and toggles.
 * assumes the destination clock and its active-low async reset.
 */
`timescale 1ns/100ps
`default_nettype none

module sync_stage2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // destination domain
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // crossing
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else if (ce) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule

`default_nettype wire

// File: logic/dbg_access_gate.sv
/*
 * debug access and security gate: debug enable decode, security code
 * fetch and compare, reset masking during break, software break
 * validity and the serial data output pin.
 * assumes a flash read port answering on CLK_SYS, and an emulator that
 * sends the 80-bit code msb first while the transfer select is high.
 */
`timescale 1ns/100ps
`default_nettype none

module dbg_access_gate (
    // system clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic CE,
    // debug link pins
    input wire logic DEBUG_CLOCK_IN,
    input wire logic DEBUG_RESET_N,
    input wire logic DEBUG_TRANSFER_SELECT,
    input wire logic DEBUG_SERIAL_IN,
    output logic DEBUG_SERIAL_OUT,
    output logic DEBUG_SERIAL_OUT_OE,
    // core side controls
    input wire logic DEBUG_MODE_SELECT_BIT,
    input wire logic RESET_PIN_N,
    input wire logic BREAK_ACTIVE,
    input wire logic WDT_RESET,
    input wire logic HW_BREAK,
    input wire logic FORCED_BREAK,
    // flash read port
    output dbg_gate_pkg::flash_rd_t FLASH_RD,
    input wire dbg_gate_pkg::flash_rsp_t FLASH_RSP,
    // results
    output dbg_gate_pkg::gate_status_t STATUS,
    output dbg_gate_pkg::reset_out_t RESETS,
    output logic SW_BREAK_ENABLE
);
    import dbg_gate_pkg::*;

    typedef enum logic [1:0] {LNK_IDLE, LNK_SHIFT} lnk_state_t;
    typedef enum logic [1:0] {LD_START, LD_REQ, LD_WAIT, LD_DONE} ld_state_t;

    function automatic logic code_equal(input id_code_t a, input id_code_t b);
        logic eq;
        eq = 1'b1;
        for (int i = 0; i < ID_BYTES; i++) begin
            eq = eq & (a[i] == b[i]);
        end
        return eq;
    endfunction

    // link domain: the debug reset pin clears it without any clock edge
    logic lnk_rst_n;
    assign lnk_rst_n = DEBUG_RESET_N & RESET_N;

    lnk_state_t lnk_state_r, lnk_state_nxt;
    logic [FRAME_CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
    logic [ID_BITS-1:0] shift_r, shift_nxt;
    logic [ID_BITS-1:0] code_r, code_nxt;
    logic code_tgl_r, code_tgl_nxt;

    always_comb begin
        lnk_state_nxt = lnk_state_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        code_nxt = code_r;
        code_tgl_nxt = code_tgl_r;
        case (lnk_state_r)
            LNK_IDLE: begin
                if (DEBUG_TRANSFER_SELECT) begin
                    lnk_state_nxt = LNK_SHIFT;
                    shift_nxt = {shift_r[ID_BITS-2:0], DEBUG_SERIAL_IN};
                    bit_cnt_nxt = FRAME_CNT_W'(1);
                end
            end
            LNK_SHIFT: begin
                if (DEBUG_TRANSFER_SELECT) begin
                    shift_nxt = {shift_r[ID_BITS-2:0], DEBUG_SERIAL_IN};
                    if (bit_cnt_r != FRAME_BITS) begin
                        bit_cnt_nxt = bit_cnt_r + FRAME_CNT_W'(1);
                    end
                end else begin
                    // short frames are dropped whole; over-long ones keep their last 80 bits
                    lnk_state_nxt = LNK_IDLE;
                    bit_cnt_nxt = CNT_RST;
                    if (bit_cnt_r == FRAME_BITS) begin
                        code_nxt = shift_r;
                        code_tgl_nxt = ~code_tgl_r;
                    end
                end
            end
            default: begin
                lnk_state_nxt = LNK_IDLE;
                bit_cnt_nxt = CNT_RST;
            end
        endcase
    end

    always_ff @(posedge DEBUG_CLOCK_IN or negedge lnk_rst_n) begin
        if (!lnk_rst_n) begin
            lnk_state_r <= LNK_IDLE;
            bit_cnt_r <= CNT_RST;
            shift_r <= '0;
            code_r <= '0;
            code_tgl_r <= 1'b0;
        end else begin
            lnk_state_r <= lnk_state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            code_r <= code_nxt;
            code_tgl_r <= code_tgl_nxt;
        end
    end

    // debug mode is brought into the link domain before it steers the pin
    logic mode_lnk;
    logic dout_r, dout_nxt;
    logic dout_oe_r, dout_oe_nxt;
    logic debug_valid_r, debug_valid_nxt;

    sync_stage2 #(.WIDTH(1), .RST_VAL(1'b0)) u_mode_to_lnk (
        .clk(DEBUG_CLOCK_IN),
        .rst_n(lnk_rst_n),
        .ce(1'b1),
        .d(debug_valid_r),
        .q(mode_lnk)
    );

    always_comb begin
        dout_nxt = mode_lnk;
        dout_oe_nxt = mode_lnk;
    end

    always_ff @(negedge DEBUG_CLOCK_IN or negedge lnk_rst_n) begin
        if (!lnk_rst_n) begin
            dout_r <= 1'b0;
            dout_oe_r <= 1'b0;
        end else begin
            dout_r <= dout_nxt;
            dout_oe_r <= dout_oe_nxt;
        end
    end

    assign DEBUG_SERIAL_OUT = dout_r;
    assign DEBUG_SERIAL_OUT_OE = dout_oe_r;

    // system domain: pins and the code toggle pass two flip-flops first
    logic dbgrst_s, rstpin_n_s, tgl_s;

    sync_stage2 #(.WIDTH(3), .RST_VAL(3'b010)) u_pins_to_sys (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .ce(CE),
        .d({DEBUG_RESET_N, RESET_PIN_N, code_tgl_r}),
        .q({dbgrst_s, rstpin_n_s, tgl_s})
    );

    logic dbgrst_d_r, dbgrst_d_nxt;
    logic tgl_d_r, tgl_d_nxt;
    logic cpu_rst_r, cpu_rst_nxt;
    logic periph_rst_r, periph_rst_nxt;
    logic port_rst_r, port_rst_nxt;
    logic dbgrst_rise;

    assign dbgrst_rise = dbgrst_s & ~dbgrst_d_r;

    always_comb begin
        dbgrst_d_nxt = dbgrst_s;
        tgl_d_nxt = tgl_s;
        debug_valid_nxt = DEBUG_MODE_SELECT_BIT & dbgrst_s;
        // a pin reset of cpu and peripherals is held back while stopped at a break; port buffers still reset
        cpu_rst_nxt = (~rstpin_n_s & ~BREAK_ACTIVE) | dbgrst_rise;
        periph_rst_nxt = ~rstpin_n_s & ~BREAK_ACTIVE;
        port_rst_nxt = ~rstpin_n_s;
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            dbgrst_d_r <= 1'b0;
            tgl_d_r <= 1'b0;
            debug_valid_r <= 1'b0;
            cpu_rst_r <= 1'b0;
            periph_rst_r <= 1'b0;
            port_rst_r <= 1'b0;
        end else if (CE) begin
            dbgrst_d_r <= dbgrst_d_nxt;
            tgl_d_r <= tgl_d_nxt;
            debug_valid_r <= debug_valid_nxt;
            cpu_rst_r <= cpu_rst_nxt;
            periph_rst_r <= periph_rst_nxt;
            port_rst_r <= port_rst_nxt;
        end
    end

    // stored code fetch: one byte per flash answer, lowest address first
    ld_state_t ld_state_r, ld_state_nxt;
    logic [3:0] ld_idx_r, ld_idx_nxt;
    id_code_t stored_r, stored_nxt;
    logic [FLASH_AW-1:0] rd_addr;

    assign rd_addr = ID_ADDR_LO + FLASH_AW'(ld_idx_r);

    always_comb begin
        ld_state_nxt = ld_state_r;
        ld_idx_nxt = ld_idx_r;
        stored_nxt = stored_r;
        case (ld_state_r)
            LD_START: begin
                ld_idx_nxt = IDX_RST;
                ld_state_nxt = LD_REQ;
            end
            LD_REQ: begin
                ld_state_nxt = LD_WAIT;
            end
            LD_WAIT: begin
                if (FLASH_RSP.valid) begin
                    stored_nxt[ld_idx_r] = FLASH_RSP.data;
                    if (ld_idx_r == IDX_LAST) begin
                        ld_state_nxt = LD_DONE;
                    end else begin
                        ld_idx_nxt = ld_idx_r + 4'h1;
                        ld_state_nxt = LD_REQ;
                    end
                end
            end
            LD_DONE: begin
                // a processor reset refetches, so a reprogrammed code counts
                if (cpu_rst_r) begin
                    ld_state_nxt = LD_START;
                end
            end
            default: begin
                ld_state_nxt = LD_START;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ld_state_r <= LD_START;
            ld_idx_r <= IDX_RST;
            stored_r <= '0;
        end else if (CE) begin
            ld_state_r <= ld_state_nxt;
            ld_idx_r <= ld_idx_nxt;
            stored_r <= stored_nxt;
        end
    end

    always_comb begin
        FLASH_RD.req = (ld_state_r == LD_REQ);
        FLASH_RD.addr = rd_addr;
    end

    // security decision on each complete code from the emulator
    logic sec_rel_r, sec_rel_nxt;
    logic emu_en;
    logic ld_done;
    logic code_new;
    id_code_t rx_code;

    assign emu_en = stored_r[EMU_EN_BYTE][EMU_EN_BIT];
    assign ld_done = (ld_state_r == LD_DONE);
    assign code_new = tgl_s ^ tgl_d_r;
    // the link holds code_r from its toggle until the next frame of 80 or more bits ends
    assign rx_code = id_code_t'(code_r);

    always_comb begin
        sec_rel_nxt = sec_rel_r;
        if (!dbgrst_s || !ld_done || !emu_en) begin
            sec_rel_nxt = SEC_RST;
        end else if (code_new) begin
            sec_rel_nxt = code_equal(rx_code, stored_r);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            sec_rel_r <= SEC_RST;
        end else if (CE) begin
            sec_rel_r <= sec_rel_nxt;
        end
    end

    // software breaks in flash: a cpu or watchdog reset clears, a hardware or forced break revives
    logic swbrk_r, swbrk_nxt;

    always_comb begin
        swbrk_nxt = swbrk_r;
        if (HW_BREAK || FORCED_BREAK) begin
            swbrk_nxt = 1'b1;
        end else if (cpu_rst_r || WDT_RESET) begin
            swbrk_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            swbrk_r <= SWBRK_RST;
        end else if (CE) begin
            swbrk_r <= swbrk_nxt;
        end
    end

    assign SW_BREAK_ENABLE = swbrk_r;

    always_comb begin
        STATUS.debug_valid = debug_valid_r;
        STATUS.emulator_enabled = emu_en & ld_done;
        // the registered release lags a reload by a cycle, so gate it here
        STATUS.security_released = sec_rel_r & debug_valid_r & emu_en & ld_done;
        STATUS.flash_read_enable = sec_rel_r & debug_valid_r & emu_en & ld_done;
        STATUS.id_loaded = ld_done;
        RESETS.cpu_reset = cpu_rst_r;
        RESETS.periph_reset = periph_rst_r;
        RESETS.port_buffer_reset = port_rst_r;
    end
endmodule

`default_nettype wire

// File: tb/dbg_gate_sva.sv
/*
 * concurrent checks on the debug access gate ports: decode, fetch,
 * release, reset masking, software break state and serial output.
 * assumes it is bound to every instance of the gate.
 */
`timescale 1ns/100ps
`default_nettype none

module dbg_gate_sva (
    // clocks and resets
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic DEBUG_CLOCK_IN,
    input wire logic DEBUG_RESET_N,
    // watched pins
    input wire logic DEBUG_SERIAL_OUT,
    input wire logic DEBUG_SERIAL_OUT_OE,
    input wire logic DEBUG_MODE_SELECT_BIT,
    input wire logic RESET_PIN_N,
    input wire logic BREAK_ACTIVE,
    input wire logic HW_BREAK,
    input wire logic FORCED_BREAK,
    input wire dbg_gate_pkg::flash_rd_t FLASH_RD,
    input wire dbg_gate_pkg::flash_rsp_t FLASH_RSP,
    input wire dbg_gate_pkg::gate_status_t STATUS,
    input wire dbg_gate_pkg::reset_out_t RESETS,
    input wire logic SW_BREAK_ENABLE
);
    import dbg_gate_pkg::*;

    a_valid_mode:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !DEBUG_MODE_SELECT_BIT |=> !STATUS.debug_valid) else $error("valid without mode bit");
    a_valid_debug_reset_n:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !DEBUG_RESET_N [*4] |=> !STATUS.debug_valid) else $error("valid with debug reset low");
    a_release_flag:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        STATUS.security_released |-> STATUS.emulator_enabled) else $error("release while disabled");
    a_release_read:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        STATUS.security_released |-> STATUS.flash_read_enable) else $error("release without reads");
    a_fetch_range:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        FLASH_RD.req |-> FLASH_RD.addr >= ID_ADDR_LO && FLASH_RD.addr <= ID_ADDR_HI)
        else $error("fetch outside code area");
    a_fetch_step:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        (FLASH_RD.req && FLASH_RD.addr != ID_ADDR_HI) ##1 FLASH_RSP.valid
        |=> FLASH_RD.req && FLASH_RD.addr == $past(FLASH_RD.addr, 2) + 24'h00_0001)
        else $error("fetch order broken");
    a_mask_break:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        BREAK_ACTIVE [*5] |-> !RESETS.periph_reset) else $error("pin reset not masked");
    a_port_reset:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !RESET_PIN_N [*4] |=> RESETS.port_buffer_reset) else $error("port buffers not reset");
    a_swbrk_hold:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !SW_BREAK_ENABLE && !HW_BREAK && !FORCED_BREAK |=> !SW_BREAK_ENABLE)
        else $error("software break rearmed alone");
    a_swbrk_arm:
    assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        HW_BREAK || FORCED_BREAK |=> SW_BREAK_ENABLE) else $error("break did not rearm");
    a_out_high:
    assert property (@(posedge DEBUG_CLOCK_IN) disable iff (!DEBUG_RESET_N || !RESET_N)
        DEBUG_SERIAL_OUT_OE |-> DEBUG_SERIAL_OUT) else $error("serial out low in debug mode");

    c_release: cover property (@(posedge CLK_SYS) $rose(STATUS.security_released));
    c_masked: cover property (@(posedge CLK_SYS) BREAK_ACTIVE && !RESET_PIN_N);
    c_swbrk_off: cover property (@(posedge CLK_SYS) $fell(SW_BREAK_ENABLE));
endmodule

bind dbg_access_gate dbg_gate_sva chk (.CLK_SYS, .RESET_N, .DEBUG_CLOCK_IN, .DEBUG_RESET_N,
    .DEBUG_SERIAL_OUT, .DEBUG_SERIAL_OUT_OE, .DEBUG_MODE_SELECT_BIT, .RESET_PIN_N,
    .BREAK_ACTIVE, .HW_BREAK, .FORCED_BREAK, .FLASH_RD, .FLASH_RSP, .STATUS, .RESETS,
    .SW_BREAK_ENABLE);

`default_nettype wire

// File: tb/dbg_emulator.sv
/*
 * behavioural debug emulator: debug reset and framed serial transfers.
 * assumes the gate samples on rising and drives on falling link edges.
 */
`timescale 1ns/100ps
`default_nettype none

module dbg_emulator (
    // link pins
    output logic dclk,
    output logic dbg_rst_n,
    output logic sel,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        dclk = 1'b0;
        dbg_rst_n = 1'b0;
        sel = 1'b0;
        sdi = 1'b1;
    end

    // clock runs only for a frame plus the idle gap, then stands still
    task automatic send(input logic [79:0] code, input int nbits);
        #7;
        for (int i = 0; i < nbits + 4; i++) begin
            sel = (i < nbits);
            sdi = (i < nbits) ? code[79 - i] : ~sdi;
            #15 dclk = 1'b1;
            #15 dclk = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// File: tb/debug_access_security_gate_tb.sv
/*
 * self-checking bench for the debug access gate: flash responder,
 * link emulator and scenario sequence. assumes the checker is bound.
 */
`timescale 1ns/100ps
`default_nettype none

module debug_access_security_gate_tb;
    import dbg_gate_pkg::*;
    logic clk, rst_n, mode, pin_n, brk, wdt, hwb, fb, dclk, dbg_rst_n, sel, sdi, sdo, oe, swe;
    logic saw_cpu;
    logic [15:0] lf = 16'hC69B;
    int errors = 0;
    int n_tests = 0;
    int nxt = 0;
    id_code_t mem, code;
    flash_rd_t frd;
    flash_rsp_t frsp;
    gate_status_t st;
    reset_out_t rs;

    dbg_access_gate dut (.CLK_SYS(clk), .RESET_N(rst_n), .CE(1'b1), .DEBUG_CLOCK_IN(dclk),
        .DEBUG_RESET_N(dbg_rst_n), .DEBUG_TRANSFER_SELECT(sel), .DEBUG_SERIAL_IN(sdi),
        .DEBUG_SERIAL_OUT(sdo), .DEBUG_SERIAL_OUT_OE(oe), .DEBUG_MODE_SELECT_BIT(mode),
        .RESET_PIN_N(pin_n), .BREAK_ACTIVE(brk), .WDT_RESET(wdt), .HW_BREAK(hwb),
        .FORCED_BREAK(fb), .FLASH_RD(frd), .FLASH_RSP(frsp), .STATUS(st), .RESETS(rs),
        .SW_BREAK_ENABLE(swe));
    dbg_emulator emu (.dclk(dclk), .dbg_rst_n(dbg_rst_n), .sel(sel), .sdi(sdi), .sdo(sdo));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic exp_rel(input id_code_t c, input id_code_t s);
        return (c == s) && s[EMU_EN_BYTE][EMU_EN_BIT];
    endfunction

    task automatic check(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic load_wait;
        cyc(25);
        for (int i = 0; i < 100 && st.id_loaded !== 1'b1; i++) cyc(1);
        check(st.id_loaded, 1'b1);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // one-cycle answer to every fetch, also while a cpu reset stands; a
    // reload only starts from a finished load, so the order simply wraps
    always @(posedge clk) begin
        frsp <= '0;
        if (rs.cpu_reset === 1'b1) begin
            saw_cpu <= 1'b1;
        end
        if (frd.req === 1'b1) begin
            check(frd.addr == ID_ADDR_LO + 24'(nxt), 1'b1);
            frsp <= {1'b1, mem[frd.addr[3:0]]};
            nxt = (nxt == 9) ? 0 : nxt + 1;
        end
    end

    initial begin
        #300000;
        errors++;
        finish_test;
    end

    initial begin
        rst_n = 1'b0;
        mode = 1'b0;
        pin_n = 1'b1;
        brk = 1'b0;
        wdt = 1'b0;
        hwb = 1'b0;
        fb = 1'b0;
        frsp = '0;
        mem = 80'hD423_F1DE_BC9A_7856_3412;
        cyc(4);
        check(swe, 1'b1);
        check(st.debug_valid, 1'b0);
        cyc(1);
        rst_n = 1'b1;
        load_wait;
        check(st.emulator_enabled, 1'b1);
        $display("load test done");
        saw_cpu = 1'b0;
        for (int k = 0; k < 4; k++) begin
            mode = k[0];
            emu.dbg_rst_n = k[1];
            cyc(6);
            check(st.debug_valid, mode & dbg_rst_n);
        end
        check(saw_cpu, 1'b1);
        load_wait;
        $display("decode test done");
        // matching code first, so every mismatch must clear the release
        for (int i = 10; i >= 0; i--) begin
            code = mem;
            lf = lfsr(lf);
            if (i < 10) code[i] = code[i] ^ (lf[7:0] | 8'h01);
            emu.send(code, 80);
            cyc(8);
            check(st.security_released, exp_rel(code, mem));
            check(st.flash_read_enable, exp_rel(code, mem));
            check(sdo & oe, 1'b1);
        end
        // a short frame after a match must leave the release standing
        emu.send(mem, 80);
        cyc(8);
        emu.send(mem, 79);
        cyc(8);
        check(st.security_released, 1'b1);
        emu.dbg_rst_n = 1'b0;
        #1;
        check(sdo | oe, 1'b0);
        cyc(5);
        check(st.security_released, 1'b0);
        $display("frame test done");
        mem[EMU_EN_BYTE][EMU_EN_BIT] = 1'b0;
        emu.dbg_rst_n = 1'b1;
        load_wait;
        check(st.emulator_enabled, 1'b0);
        emu.send(mem, 80);
        cyc(8);
        check(st.security_released, 1'b0);
        $display("flag test done");
        brk = 1'b1;
        pin_n = 1'b0;
        cyc(8);
        check(rs.cpu_reset | rs.periph_reset, 1'b0);
        check(rs.port_buffer_reset, 1'b1);
        pin_n = 1'b1;
        brk = 1'b0;
        cyc(5);
        pin_n = 1'b0;
        cyc(5);
        check(rs.cpu_reset & rs.periph_reset, 1'b1);
        pin_n = 1'b1;
        load_wait;
        check(swe, 1'b0);
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            lf = lfsr(lf);
            hwb = k[0];
            fb = ~k[0];
            cyc(1);
            hwb = 1'b0;
            fb = 1'b0;
            cyc(2);
            check(swe, 1'b1);
            wdt = 1'b1;
            cyc(1);
            wdt = 1'b0;
            cyc(3 + lf[3:0]);
            check(swe, 1'b0);
        end
        $display("break test done");
        finish_test;
    end
endmodule

`default_nettype wire
